// file: pkg/dbg_pkg.sv
package dbg_pkg;
  // Byte addresses of the registers on the Wishbone bus, one 32-bit register every 4 bytes.
  localparam logic [7:0] ADDR_DEBUG_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DEBUG_STATUS = 8'h04;
  localparam logic [7:0] ADDR_VECTOR_CATCH = 8'h08;
  localparam logic [7:0] ADDR_W0_BASE = 8'h20;
  localparam logic [7:0] ADDR_W1_BASE = 8'h40;
  // Offsets within a watchpoint block.
  localparam logic [4:0] OFS_ADDR_VALUE = 5'h00;
  localparam logic [4:0] OFS_ADDR_MASK = 5'h04;
  localparam logic [4:0] OFS_DATA_VALUE = 5'h08;
  localparam logic [4:0] OFS_DATA_MASK = 5'h0c;
  localparam logic [4:0] OFS_CTRL_VALUE = 5'h10;
  localparam logic [4:0] OFS_CTRL_MASK = 5'h14;
  // Register widths.
  localparam int DEBUG_CONTROL_W = 4;
  localparam int DEBUG_STATUS_W = 5;
  localparam int VECTOR_CATCH_W = 8;
  localparam int CTRL_VALUE_W = 9;
  localparam int CTRL_MASK_W = 8;
  // Field positions.
  localparam int STEP_BIT = 3;
  localparam int ST_REQ = 0;
  localparam int ST_ACK = 1;
  localparam int ST_IRQEN = 2;
  localparam int ST_SYSTEM_ACCESS_COMPLETE = 3;
  localparam int ST_ISA = 4;
  localparam int CF_ISA = 2;
  localparam int CF_PRIV = 7;
  localparam int CF_SEL = 3;
  localparam int CF_EXT = 4;
  localparam int CF_CHAIN = 5;
  localparam int CF_RANGE = 6;
  localparam int CF_ENABLE = 8;
  // Values after reset.
  localparam logic [3:0] DEBUG_CONTROL_RST = 4'h0;
  localparam logic [7:0] VECTOR_CATCH_RST = 8'h00;
  localparam logic [8:0] CTRL_VALUE_RST = 9'h000;
  localparam logic [7:0] CTRL_MASK_RST = 8'h03;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'hffff_ffff;
  localparam int SYNC_STAGES = 2;
endpackage

// file: src/debug_watch_catch_step.sv
module debug_watch_catch_step #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic TEST_RST_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Instruction fetch from the core
  input wire logic FETCH_VALID,
  input wire logic [ADDR_W-1:0] FETCH_ADDR,
  input wire logic [DATA_W-1:0] FETCH_DATA,
  input wire logic COMPRESSED_ISA_STATE,
  input wire logic INSTR_USER_PRIVILEGE_FLAG,
  input wire logic EXCEPTION_ENTRY,
  input wire logic INSTR_EXECUTED,
  // External conditions and core state, asynchronous
  input wire logic EXTERNAL_WATCH_CONDITION_W0,
  input wire logic EXTERNAL_WATCH_CONDITION_W1,
  input wire logic DEBUG_REQUEST_IN,
  input wire logic DEBUG_ACKNOWLEDGE_OUT,
  input wire logic CORE_IRQ_ENABLE_STATE,
  input wire logic SYSTEM_ACCESS_COMPLETE,
  // To the pipeline
  output logic BREAKPOINT,
  output logic CHAIN_LATCH_OUT,
  output logic RANGE_COMPARE_OUT
);
  // Refuse widths that the 32-bit comparators cannot serve.
  if (ADDR_W < 4 || ADDR_W > 32 || DATA_W < 1 || DATA_W > 32) begin
    $error("unsupported address or data width");
  end

  typedef enum logic [1:0] {STEP_IDLE, STEP_RUN, STEP_HIT} step_e;

  function automatic logic masked_eq(input logic [31:0] a,
                                     input logic [31:0] b,
                                     input logic [31:0] m);
    masked_eq = ((a ^ b) & ~m) == 32'h0000_0000;
  endfunction

  // Synchronisers for asynchronous inputs.
  logic [1:0] s_ext0, s_ext1, s_req, s_ack, s_irq, s_sys;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_ext0 <= 2'h0;
      s_ext1 <= 2'h0;
      s_req <= 2'h0;
      s_ack <= 2'h0;
      s_irq <= 2'h0;
      s_sys <= 2'h0;
    end else begin
      s_ext0 <= {s_ext0[0], EXTERNAL_WATCH_CONDITION_W0};
      s_ext1 <= {s_ext1[0], EXTERNAL_WATCH_CONDITION_W1};
      s_req <= {s_req[0], DEBUG_REQUEST_IN};
      s_ack <= {s_ack[0], DEBUG_ACKNOWLEDGE_OUT};
      s_irq <= {s_irq[0], CORE_IRQ_ENABLE_STATE};
      s_sys <= {s_sys[0], SYSTEM_ACCESS_COMPLETE};
    end
  end
  logic [1:0] s_trst;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      s_trst <= 2'h0;
    end else begin
      s_trst <= {s_trst[0], TEST_RST_N};
    end
  end
  wire trst_low = !s_trst[1];
  wire ack_sync = s_ack[1];

  // Registers.
  logic [3:0] debug_control;
  logic [7:0] vector_catch;
  logic [31:0] av [2];
  logic [31:0] am [2];
  logic [31:0] dv [2];
  logic [31:0] dm [2];
  logic [8:0] cv [2];
  logic [7:0] cm [2];
  logic [4:0] debug_status;

  // Bus decode.
  wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wr = req && WB_WE_I;
  wire [4:0] ofs = WB_ADR_I[4:0];
  wire in_w0 = WB_ADR_I[7:5] == dbg_pkg::ADDR_W0_BASE[7:5];
  wire in_w1 = WB_ADR_I[7:5] == dbg_pkg::ADDR_W1_BASE[7:5];
  wire hit_ctl = WB_ADR_I == dbg_pkg::ADDR_DEBUG_CONTROL;
  wire hit_vc = WB_ADR_I == dbg_pkg::ADDR_VECTOR_CATCH;
  wire [1:0] hit_w = {in_w1, in_w0};
  wire [31:0] wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                       {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  wire [31:0] ctl_new = merge({28'h0, debug_control}, WB_DAT_I, wmask);
  wire [31:0] vc_new = merge({24'h0, vector_catch}, WB_DAT_I, wmask);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= req;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      debug_control <= dbg_pkg::DEBUG_CONTROL_RST;
      vector_catch <= dbg_pkg::VECTOR_CATCH_RST;
    end else begin
      if (wr && hit_ctl) begin
        debug_control <= ctl_new[3:0];
      end
      if (wr && hit_vc) begin
        vector_catch <= vc_new[7:0];
      end
    end
  end

  wire [1:0] cv_wr;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_wr
      wire w = wr && hit_w[gi];
      assign cv_wr[gi] = w && ofs == dbg_pkg::OFS_CTRL_VALUE;
      wire [31:0] cv_new = merge({23'h0, cv[gi]}, WB_DAT_I, wmask);
      wire [31:0] cm_new = merge({24'h0, cm[gi]}, WB_DAT_I, wmask);
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          av[gi] <= dbg_pkg::WORD_RST;
          am[gi] <= dbg_pkg::MASK_RST;
          dv[gi] <= dbg_pkg::WORD_RST;
          dm[gi] <= dbg_pkg::MASK_RST;
          cv[gi] <= dbg_pkg::CTRL_VALUE_RST;
          cm[gi] <= dbg_pkg::CTRL_MASK_RST;
        end else if (w) begin
          if (ofs == dbg_pkg::OFS_ADDR_VALUE) begin
            av[gi] <= merge(av[gi], WB_DAT_I, wmask);
          end
          if (ofs == dbg_pkg::OFS_ADDR_MASK) begin
            am[gi] <= merge(am[gi], WB_DAT_I, wmask);
          end
          if (ofs == dbg_pkg::OFS_DATA_VALUE) begin
            dv[gi] <= merge(dv[gi], WB_DAT_I, wmask);
          end
          if (ofs == dbg_pkg::OFS_DATA_MASK) begin
            dm[gi] <= merge(dm[gi], WB_DAT_I, wmask);
          end
          if (cv_wr[gi]) begin
            cv[gi] <= cv_new[8:0];
          end
          if (ofs == dbg_pkg::OFS_CTRL_MASK) begin
            // Select bit cannot be masked.
            cm[gi] <= cm_new[7:0] & 8'hf7;
          end
        end
      end
    end
  endgenerate

  // Status: writes to it are not decoded at all.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      debug_status <= 5'h00;
    end else begin
      debug_status[dbg_pkg::ST_REQ] <= s_req[1];
      debug_status[dbg_pkg::ST_ACK] <= ack_sync;
      // Interrupt enable is held off while in debug state.
      debug_status[dbg_pkg::ST_IRQEN] <= s_irq[1] && !ack_sync;
      debug_status[dbg_pkg::ST_SYSTEM_ACCESS_COMPLETE] <= s_sys[1];
      debug_status[dbg_pkg::ST_ISA] <= COMPRESSED_ISA_STATE;
    end
  end

  // Read mux.
  wire [31:0] rd_w [2];
  generate
    for (gi = 0; gi < 2; gi++) begin : g_rd
      assign rd_w[gi] =
        (ofs == dbg_pkg::OFS_ADDR_VALUE) ? av[gi] :
        (ofs == dbg_pkg::OFS_ADDR_MASK) ? am[gi] :
        (ofs == dbg_pkg::OFS_DATA_VALUE) ? dv[gi] :
        (ofs == dbg_pkg::OFS_DATA_MASK) ? dm[gi] :
        (ofs == dbg_pkg::OFS_CTRL_VALUE) ? {23'h0, cv[gi]} :
        (ofs == dbg_pkg::OFS_CTRL_MASK) ? {24'h0, cm[gi]} : 32'h0;
    end
  endgenerate
  wire hit_st = WB_ADR_I == dbg_pkg::ADDR_DEBUG_STATUS;
  wire [31:0] rd_data =
    hit_ctl ? {28'h0, debug_control} :
    hit_st ? {27'h0, debug_status} :
    hit_vc ? {24'h0, vector_catch} :
    in_w0 ? rd_w[0] :
    in_w1 ? rd_w[1] : 32'h0;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      WB_DAT_O <= 32'h0;
    end else if (req && !WB_WE_I) begin
      WB_DAT_O <= rd_data;
    end
  end

  // Watchpoint comparators.
  logic chain_q;
  wire [31:0] f_addr = 32'(FETCH_ADDR);
  wire [31:0] f_data = 32'(FETCH_DATA);
  wire [1:0] f_ext = {s_ext1[1], s_ext0[1]};
  wire [1:0] addr_hit, data_hit, ctl_hit, wp_break;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cmp
      wire [7:0] cur;
      wire chain_in = (gi == 0) ? chain_q : 1'b0;
      wire range_in = (gi == 0) ? addr_hit[1] : 1'b0;
      // Bits 1:0 compare nothing, so the required mask of 11 hides no field.
      assign cur[0] = 1'b0;
      assign cur[1] = 1'b0;
      assign cur[dbg_pkg::CF_ISA] = COMPRESSED_ISA_STATE;
      assign cur[dbg_pkg::CF_SEL] = 1'b0;
      assign cur[dbg_pkg::CF_EXT] = f_ext[gi];
      assign cur[dbg_pkg::CF_CHAIN] = chain_in;
      assign cur[dbg_pkg::CF_RANGE] = range_in;
      assign cur[dbg_pkg::CF_PRIV] = INSTR_USER_PRIVILEGE_FLAG;
      assign addr_hit[gi] = masked_eq(f_addr, av[gi], am[gi]);
      assign data_hit[gi] = masked_eq(f_data, dv[gi], dm[gi]);
      // Only the instruction interface is watched here.
      assign ctl_hit[gi] = !cv[gi][dbg_pkg::CF_SEL] &&
        masked_eq({24'h0, cur}, {24'h0, cv[gi][7:0]}, {24'h0, cm[gi]});
      assign wp_break[gi] = FETCH_VALID && addr_hit[gi] && data_hit[gi] &&
        ctl_hit[gi] && cv[gi][dbg_pkg::CF_ENABLE];
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || trst_low || cv_wr[1] || cv_wr[0]) begin
      chain_q <= 1'b0;
    end else if (FETCH_VALID && addr_hit[1] && ctl_hit[1]) begin
      chain_q <= data_hit[1];
    end
  end

  // Vector catch: each bit covers one word-aligned vector.
  wire [2:0] vec_idx = f_addr[4:2];
  wire vec_space = f_addr[31:5] == 27'h0 && f_addr[1:0] == 2'h0;
  wire catch_hit = FETCH_VALID && EXCEPTION_ENTRY && vec_space &&
    vector_catch[vec_idx];

  // Single step sequencer, independent of the comparators.
  step_e step_state, next_step;
  logic ack_d;
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ack_d <= 1'b0;
    end else begin
      ack_d <= ack_sync;
    end
  end
  wire leave_debug = ack_d && !ack_sync;
  wire step_en = debug_control[dbg_pkg::STEP_BIT];
  always_comb begin
    next_step = step_state;
    case (step_state)
      STEP_IDLE: begin
        if (leave_debug && step_en) begin
          next_step = STEP_RUN;
        end
      end
      STEP_RUN: begin
        if (INSTR_EXECUTED) begin
          next_step = STEP_HIT;
        end
      end
      STEP_HIT: begin
        if (ack_sync) begin
          next_step = STEP_IDLE;
        end
      end
      default: next_step = STEP_IDLE;
    endcase
  end
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      step_state <= STEP_IDLE;
    end else begin
      step_state <= next_step;
    end
  end
  // The step break lands on the next fetch after one executed instruction.
  wire step_break = step_state == STEP_HIT && FETCH_VALID;

  assign BREAKPOINT = |wp_break || catch_hit || step_break;
  assign CHAIN_LATCH_OUT = chain_q;
  assign RANGE_COMPARE_OUT = addr_hit[1];
endmodule

// file: tb/dwcs_asserts.sv
module dwcs_asserts (
  // Clock and resets
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic TEST_RST_N,
  // Register bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  // Core side
  input wire logic FETCH_VALID,
  input wire logic COMPRESSED_ISA_STATE,
  input wire logic DEBUG_REQUEST_IN,
  input wire logic SYSTEM_ACCESS_COMPLETE,
  input wire logic CHAIN_LATCH_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ST = dbg_pkg::ADDR_DEBUG_STATUS;
  localparam logic [7:0] CT = dbg_pkg::ADDR_DEBUG_CONTROL;
  localparam logic [7:0] W1CV = dbg_pkg::ADDR_W1_BASE + 8'h10;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_take(logic w, logic [7:0] a);
    WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I == w && WB_ADR_I == a;
  endsequence
  AST_ACK_PULSE: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("access not answered by one ack pulse");
  AST_STATUS_WIDTH: assert property (
    s_take(1'b0, ST) |=> WB_ACK_O && WB_DAT_O[31:5] == 27'h0)
    else $error("status read shows bits above bit 4");
  AST_CTRL_WIDTH: assert property (
    s_take(1'b0, CT) |=> WB_DAT_O[31:4] == 28'h0)
    else $error("control read shows bits above bit 3");
  AST_REQ_SYNC: assert property (
    DEBUG_REQUEST_IN [*4] ##0 s_take(1'b0, ST) |=> WB_DAT_O[0])
    else $error("status bit 0 misses a steady request");
  AST_SYSTEM_ACCESS_COMPLETE_SYNC: assert property (
    (!SYSTEM_ACCESS_COMPLETE) [*4] ##0 s_take(1'b0, ST) |=> !WB_DAT_O[3])
    else $error("status bit 3 set with access incomplete");
  AST_ISA_STATUS: assert property (
    COMPRESSED_ISA_STATE [*3] ##0 s_take(1'b0, ST) |=> WB_DAT_O[4])
    else $error("status bit 4 misses the compressed state");
  AST_TRST_CLEAR: assert property (
    (!TEST_RST_N) [*3] |=> ##1 !CHAIN_LATCH_OUT)
    else $error("chain latch survives test reset");
  AST_CV_CLEAR: assert property (
    s_take(1'b1, W1CV) ##1 !FETCH_VALID |=> !CHAIN_LATCH_OUT)
    else $error("chain latch survives control value write");
endmodule

bind debug_watch_catch_step dwcs_asserts u_dwcs_asserts (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .TEST_RST_N(TEST_RST_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .FETCH_VALID(FETCH_VALID), .COMPRESSED_ISA_STATE(COMPRESSED_ISA_STATE),
  .DEBUG_REQUEST_IN(DEBUG_REQUEST_IN),
  .SYSTEM_ACCESS_COMPLETE(SYSTEM_ACCESS_COMPLETE),
  .CHAIN_LATCH_OUT(CHAIN_LATCH_OUT)
);

// file: tb/core_model.sv
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic go,
  input wire logic exc,
  input wire logic resume,
  input wire logic [31:0] addr,
  input wire logic [31:0] data,
  // Fetch side of the block
  input wire logic bkpt,
  output logic valid,
  output logic [31:0] f_addr,
  output logic [31:0] f_data,
  output logic f_exc,
  output logic executed,
  output logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside a fetch the buses flip every cycle, so a stale value comes back only every second cycle.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid <= 1'b0;
      f_exc <= 1'b0;
      executed <= 1'b0;
      ack <= 1'b0;
      f_addr <= 32'h0;
      f_data <= 32'h0;
    end else begin
      valid <= go && !ack;
      f_exc <= go && exc;
      f_addr <= go ? addr : ~f_addr;
      f_data <= go ? data : ~f_data;
      executed <= valid && !bkpt;
      if (valid && bkpt) begin
        ack <= 1'b1;
      end else if (resume) begin
        ack <= 1'b0;
      end
    end
  end
endmodule

// file: tb/debug_watch_catch_step_bench.sv
module debug_watch_catch_step_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CT = dbg_pkg::ADDR_DEBUG_CONTROL;
  localparam logic [7:0] ST = dbg_pkg::ADDR_DEBUG_STATUS;
  localparam logic [7:0] VC = dbg_pkg::ADDR_VECTOR_CATCH;
  localparam logic [7:0] W0 = dbg_pkg::ADDR_W0_BASE;
  localparam logic [7:0] W1 = dbg_pkg::ADDR_W1_BASE;
  logic clk, rst_n, trst_n, cyc, stb, we, ack, bkpt, chain, rng;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, fa, fd, ma, md;
  logic fv, fx, isa, priv, exe, e0, e1, req, dack, irq, sysc;
  logic go, exc, res, h, r;
  int n_fail;
  int check_count;

  debug_watch_catch_step u_debug_watch_catch_step (
    .CORE_CLK(clk), .RST_N(rst_n), .TEST_RST_N(trst_n),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .FETCH_VALID(fv), .FETCH_ADDR(fa), .FETCH_DATA(fd),
    .COMPRESSED_ISA_STATE(isa), .INSTR_USER_PRIVILEGE_FLAG(priv),
    .EXCEPTION_ENTRY(fx), .INSTR_EXECUTED(exe),
    .EXTERNAL_WATCH_CONDITION_W0(e0), .EXTERNAL_WATCH_CONDITION_W1(e1),
    .DEBUG_REQUEST_IN(req), .DEBUG_ACKNOWLEDGE_OUT(dack),
    .CORE_IRQ_ENABLE_STATE(irq), .SYSTEM_ACCESS_COMPLETE(sysc),
    .BREAKPOINT(bkpt), .CHAIN_LATCH_OUT(chain), .RANGE_COMPARE_OUT(rng)
  );
  core_model u_core_model (
    .clk(clk), .rst_n(rst_n), .go(go), .exc(exc), .resume(res),
    .addr(ma), .data(md), .bkpt(bkpt), .valid(fv), .f_addr(fa),
    .f_data(fd), .f_exc(fx), .executed(exe), .ack(dack)
  );

  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rc(string s, logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(s, q, e);
  endtask
  task automatic wp(logic [7:0] b, logic [31:0] av, logic [31:0] am,
                    logic [31:0] dv, logic [31:0] dm, logic [8:0] cv,
                    logic [7:0] cm);
    wr(b, av);
    wr(b + 8'h04, am);
    wr(b + 8'h08, dv);
    wr(b + 8'h0c, dm);
    wr(b + 8'h14, {24'h0, cm});
    wr(b + 8'h10, {23'h0, cv});
  endtask
  task automatic fetch(logic [31:0] a, logic [31:0] d, logic e);
    go <= 1'b1;
    exc <= e;
    ma <= a;
    md <= d;
    @(posedge clk);
    go <= 1'b0;
    #1 r = rng;
    repeat (3) @(posedge clk);
    h = dack;
  endtask
  task automatic resume_core;
    res <= 1'b1;
    @(posedge clk);
    res <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs;
    rc("ctrl reset", CT, 32'h0);
    rc("ctrl mask reset", W0 + 8'h14, 32'h3);
    wr(CT, 32'hffff_fff7);
    rc("ctrl width", CT, 32'h7);
    wr(CT, 32'h0);
    rc("unmapped", 8'h1c, 32'h0);
    req <= 1'b1;
    irq <= 1'b1;
    sysc <= 1'b1;
    isa <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ST, 32'h0);
    rc("status run", ST, 32'h1d);
    $display("test registers done");
  endtask
  task automatic t_watch;
    e0 <= 1'b1;
    wp(W1, 32'h100, 32'h0, 32'h0, 32'hffff_ffff, 9'h000, 8'hff);
    fetch(32'h100, 32'h0, 1'b0);
    chk("enable off", h, 1'b0);
    chk("range out", r, 1'b1);
    fetch(32'h104, 32'h0, 1'b0);
    chk("range miss", r, 1'b0);
    wp(W1, 32'h100, 32'h0, 32'h0, 32'hffff_ffff, 9'h110, 8'hef);
    fetch(32'h100, 32'h0, 1'b0);
    chk("ext low", h, 1'b0);
    e1 <= 1'b1;
    repeat (4) @(posedge clk);
    fetch(32'h100, 32'h0, 1'b0);
    chk("ext high", h, 1'b1);
    resume_core;
    wp(W1, 32'h100, 32'h0, 32'h0, 32'hffff_ffff, 9'h184, 8'h7b);
    fetch(32'h100, 32'h0, 1'b0);
    chk("user fetch", h, 1'b0);
    priv <= 1'b1;
    fetch(32'h100, 32'h0, 1'b0);
    chk("privileged fetch", h, 1'b1);
    resume_core;
    isa <= 1'b0;
    fetch(32'h100, 32'h0, 1'b0);
    chk("native fetch", h, 1'b0);
    $display("test watchpoint done");
  endtask
  task automatic t_link;
    wp(W1, 32'h100, 32'h0, 32'hab, 32'h0, 9'h000, 8'hff);
    wp(W0, 32'h0, 32'hffff_ffff, 32'h0, 32'hffff_ffff, 9'h140, 8'hbf);
    fetch(32'h104, 32'hab, 1'b0);
    chk("range low", h, 1'b0);
    fetch(32'h100, 32'hab, 1'b0);
    chk("range high", h, 1'b1);
    chk("chain set", chain, 1'b1);
    resume_core;
    chk("chain kept", chain, 1'b1);
    wr(W1 + 8'h10, 32'h0);
    chk("chain cv clear", chain, 1'b0);
    wp(W0, 32'h0, 32'hffff_ffff, 32'h0, 32'hffff_ffff, 9'h120, 8'hdf);
    fetch(32'h100, 32'hcd, 1'b0);
    chk("chain data miss", chain, 1'b0);
    fetch(32'h100, 32'hab, 1'b0);
    fetch(32'h104, 32'h0, 1'b0);
    chk("chained break", h, 1'b1);
    resume_core;
    trst_n <= 1'b0;
    repeat (4) @(posedge clk);
    trst_n <= 1'b1;
    chk("chain test reset", chain, 1'b0);
    wr(W0 + 8'h10, 32'h0);
    $display("test chain done");
  endtask
  task automatic t_catch_step;
    for (int n = 0; n < 8; n++) begin
      wr(VC, 32'h1 << n);
      fetch(32'(4 * n), 32'h0, 1'b0);
      chk("branch", h, 1'b0);
      fetch(32'(4 * n), 32'h0, 1'b1);
      chk("catch", h, 1'b1);
      if (n != 7) begin
        resume_core;
      end
    end
    {req, sysc, isa} <= 3'b000;
    repeat (4) @(posedge clk);
    rc("status halted", ST, 32'h02);
    wr(VC, 32'h0);
    wr(CT, 32'h8);
    resume_core;
    fetch(32'h200, 32'h0, 1'b0);
    chk("step first", h, 1'b0);
    fetch(32'h204, 32'h0, 1'b0);
    chk("step again", h, 1'b1);
    wr(CT, 32'h0);
    resume_core;
    fetch(32'h208, 32'h0, 1'b0);
    chk("no step", h, 1'b0);
    $display("test catch and step done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    n_fail = 0;
    check_count = 0;
    trst_n = 1'b1;
    {rst_n, cyc, stb, we, go, exc, res, h, r} = '0;
    {isa, priv, e0, e1, req, irq, sysc} = '0;
    {adr, wdat, ma, md} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_watch;
    t_link;
    t_catch_step;
    report_and_stop;
  end
endmodule
